// ### rhs_pkg.sv
package rhs_pkg;

  // --------------------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] RHS_CMD_HUB_RD   = 8'h14;
  localparam logic [7:0] RHS_CMD_HUB_WR   = 8'h94;
  localparam logic [7:0] RHS_CMD_PORT1_RD = 8'h15;
  localparam logic [7:0] RHS_CMD_PORT1_WR = 8'h95;
  localparam logic [7:0] RHS_CMD_PORT2_RD = 8'h16;
  localparam logic [7:0] RHS_CMD_PORT2_WR = 8'h96;

  // --------------------------------------------------------------------------
  // Hub status bit positions
  // --------------------------------------------------------------------------
  localparam int RHS_HUB_LOCAL_PWR     = 0;
  localparam int RHS_HUB_OVERCURRENT   = 1;
  localparam int RHS_HUB_WAKE_EN       = 15;
  localparam int RHS_HUB_LOCAL_PWR_CHG = 16;
  localparam int RHS_HUB_OC_CHG        = 17;
  localparam int RHS_HUB_WAKE_CLR      = 31;

  // --------------------------------------------------------------------------
  // Port status bit positions
  // --------------------------------------------------------------------------
  localparam int RHS_P_CONNECT     = 0;
  localparam int RHS_P_ENABLED     = 1;
  localparam int RHS_P_SUSPENDED   = 2;
  localparam int RHS_P_OVERCURRENT = 3;
  localparam int RHS_P_IN_RESET    = 4;
  localparam int RHS_P_POWER_ON    = 8;
  localparam int RHS_P_SLOW_DEV    = 9;
  localparam int RHS_P_CONNECT_CHG = 16;
  localparam int RHS_P_ENABLE_CHG  = 17;
  localparam int RHS_P_SUSPEND_CHG = 18;
  localparam int RHS_P_OC_CHG      = 19;
  localparam int RHS_P_RESET_CHG   = 20;

  localparam logic [31:0] RHS_PORT_RESET  = 32'h0000_0000;
  localparam logic [31:0] RHS_PORT_CHG_MASK = 32'h001F_0000;
  localparam int RHS_NUM_PORTS   = 2;

endpackage : rhs_pkg

// ### rhs_port.sv
module rhs_port
  import rhs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        conn_sync,
  input  wire logic        slow_sync,
  input  wire logic        ocur_sync,
  input  wire logic        enable_lost,
  input  wire logic        reset_done,
  input  wire logic        resume_done,
  input  wire logic        pwr_on_pulse,
  input  wire logic        pwr_off_pulse,
  input  wire logic        wr_apply,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] status,
  output logic             connect_change_event
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic conn;
    logic ocur;
    logic power;
    logic enabled;
    logic susp;
    logic in_reset;
    logic [4:0] chg;
    logic conn_evt;
  } rhs_port_t;

  rhs_port_t st_r;
  rhs_port_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.conn = conn_sync;
    st_nxt.ocur = ocur_sync;
    st_nxt.conn_evt = 1'b0;
    // Write-one clears first, so hardware sets below win the same cycle
    if (wr_apply) begin
      st_nxt.chg = st_r.chg & ~wr_data[RHS_P_RESET_CHG:RHS_P_CONNECT_CHG];
      if (wr_data[RHS_P_CONNECT]) st_nxt.enabled = st_r.conn;
      if (wr_data[RHS_P_ENABLED]) st_nxt.enabled = 1'b0;
      if (wr_data[RHS_P_SUSPENDED]) st_nxt.susp = st_r.conn;
      if (wr_data[RHS_P_IN_RESET]) st_nxt.in_reset = st_r.conn;
      // Enable, suspend and reset sets on an empty port flag a connect change for the driver
      if (!st_r.conn && (wr_data[RHS_P_CONNECT] | wr_data[RHS_P_SUSPENDED]
                         | wr_data[RHS_P_IN_RESET])) begin
        st_nxt.chg[0] = 1'b1;
      end
      if (wr_data[RHS_P_OVERCURRENT]) st_nxt.susp = 1'b0;
      if (wr_data[RHS_P_POWER_ON]) st_nxt.power = 1'b1;
      if (wr_data[RHS_P_SLOW_DEV]) st_nxt.power = 1'b0;
    end
    if (pwr_on_pulse) st_nxt.power = 1'b1;
    if (pwr_off_pulse) st_nxt.power = 1'b0;
    if (conn_sync != st_r.conn) begin
      st_nxt.chg[0] = 1'b1;
      st_nxt.conn_evt = 1'b1;
    end
    if (enable_lost && st_r.enabled) begin
      st_nxt.enabled = 1'b0;
      st_nxt.chg[1] = 1'b1;
    end
    if (resume_done) begin
      st_nxt.susp = 1'b0;
      st_nxt.chg[2] = 1'b1;
    end
    if (ocur_sync != st_r.ocur) st_nxt.chg[3] = 1'b1;
    if (reset_done) begin
      st_nxt.in_reset = 1'b0;
      st_nxt.enabled = st_r.conn;
      st_nxt.chg[4] = 1'b1;
      st_nxt.chg[2] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    status = RHS_PORT_RESET;
    status[RHS_P_RESET_CHG:RHS_P_CONNECT_CHG] = st_r.chg;
    status[RHS_P_CONNECT]     = st_r.conn;
    status[RHS_P_ENABLED]     = st_r.enabled;
    status[RHS_P_SUSPENDED]   = st_r.susp;
    status[RHS_P_OVERCURRENT] = st_r.ocur;
    status[RHS_P_IN_RESET]    = st_r.in_reset;
    status[RHS_P_POWER_ON]    = st_r.power;
    status[RHS_P_SLOW_DEV]    = slow_sync & st_r.conn;
  end

  assign connect_change_event = st_r.conn_evt;

endmodule : rhs_port

// ### rhs_hub.sv
module rhs_hub
  import rhs_pkg::*;
#(
  parameter int NUM_PORTS = RHS_NUM_PORTS
)(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [31:0]          cmd_wdata,
  input  wire logic                 power_switch_select,
  input  wire logic                 per_port_ocur_mode,
  input  wire logic [NUM_PORTS-1:0] per_port_power_mask,
  input  wire logic                 transaction_busy,
  input  wire logic                 controller_suspended,
  input  wire logic                 overcurrent_pin,
  input  wire logic [NUM_PORTS-1:0] connect_pin,
  input  wire logic [NUM_PORTS-1:0] slow_pin,
  input  wire logic [NUM_PORTS-1:0] port_ocur_pin,
  input  wire logic [NUM_PORTS-1:0] enable_lost,
  input  wire logic [NUM_PORTS-1:0] reset_done,
  input  wire logic [NUM_PORTS-1:0] resume_done,
  output logic      [31:0]          cmd_rdata,
  output logic                      cmd_rvalid,
  output logic      [NUM_PORTS-1:0] port_power_on,
  output logic                      resume_seen_interrupt,
  output logic                      resume_request
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  // Port command codes exist for only two ports, so the port count is fixed
  if (NUM_PORTS != RHS_NUM_PORTS) begin : g_bad_ports
    $error("rhs_hub supports exactly two ports");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                 oc_s1;
    logic                 oc_s2;
    logic [NUM_PORTS-1:0] cn_s1;
    logic [NUM_PORTS-1:0] cn_s2;
    logic [NUM_PORTS-1:0] sl_s1;
    logic [NUM_PORTS-1:0] sl_s2;
    logic [NUM_PORTS-1:0] po_s1;
    logic [NUM_PORTS-1:0] po_s2;
    logic                 oc_last;
    logic                 wake_en;
    logic                 oc_chg;
    logic                 pend;
    logic [NUM_PORTS-1:0] pend_sel;
    logic [31:0]          pend_data;
    logic [NUM_PORTS-1:0] pwr_on;
    logic [NUM_PORTS-1:0] pwr_off;
    logic [31:0]          rdata;
    logic                 rvalid;
    logic [NUM_PORTS-1:0] pwr_out;
    logic                 resume_irq;
    logic                 resume_req;
  } rhs_hub_t;

  rhs_hub_t st_r;
  rhs_hub_t st_nxt;

  logic [31:0]          port_stat [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_conn_evt;
  logic [NUM_PORTS-1:0] port_apply;
  logic [31:0]          hub_view;
  logic                 oc_global;

  // --------------------------------------------------------------------------
  // Ports
  // --------------------------------------------------------------------------
  // Postponed writes land only when no transaction is on the bus
  assign port_apply = (st_r.pend && !transaction_busy) ? st_r.pend_sel : '0;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    rhs_port u_port (
      .clk_sys              (clk_sys),
      .rst_n                (rst_n),
      .conn_sync            (st_r.cn_s2[i]),
      .slow_sync            (st_r.sl_s2[i]),
      .ocur_sync            (st_r.po_s2[i]),
      .enable_lost          (enable_lost[i]),
      .reset_done           (reset_done[i]),
      .resume_done          (resume_done[i]),
      .pwr_on_pulse         (st_r.pwr_on[i]),
      .pwr_off_pulse        (st_r.pwr_off[i]),
      .wr_apply             (port_apply[i]),
      .wr_data              (st_r.pend_data),
      .status               (port_stat[i]),
      .connect_change_event (port_conn_evt[i])
    );
  end

  // --------------------------------------------------------------------------
  // Hub status view
  // --------------------------------------------------------------------------
  assign oc_global = st_r.oc_s2 & ~per_port_ocur_mode;

  always_comb begin
    hub_view = '0;
    hub_view[RHS_HUB_OVERCURRENT]   = st_r.oc_last;
    hub_view[RHS_HUB_WAKE_EN]       = st_r.wake_en;
    hub_view[RHS_HUB_OC_CHG]        = st_r.oc_chg;
    hub_view[RHS_HUB_LOCAL_PWR]     = 1'b0;
    hub_view[RHS_HUB_LOCAL_PWR_CHG] = 1'b0;
  end

  always_comb begin
    logic [NUM_PORTS-1:0] sel;
    sel = power_switch_select ? ~per_port_power_mask : '1;
    st_nxt = st_r;
    st_nxt.oc_s1 = overcurrent_pin;
    st_nxt.oc_s2 = st_r.oc_s1;
    st_nxt.cn_s1 = connect_pin;
    st_nxt.cn_s2 = st_r.cn_s1;
    st_nxt.sl_s1 = slow_pin;
    st_nxt.sl_s2 = st_r.sl_s1;
    st_nxt.po_s1 = port_ocur_pin;
    st_nxt.po_s2 = st_r.po_s1;
    st_nxt.oc_last = oc_global;
    st_nxt.pwr_on = '0;
    st_nxt.pwr_off = '0;
    st_nxt.rvalid = 1'b0;
    st_nxt.resume_irq = 1'b0;
    st_nxt.resume_req = 1'b0;
    if (port_apply != '0) st_nxt.pend = 1'b0;
    if (cmd_valid) begin
      unique case (cmd_code)
        RHS_CMD_HUB_RD: begin
          st_nxt.rdata = hub_view;
          st_nxt.rvalid = 1'b1;
        end
        RHS_CMD_PORT1_RD: begin
          st_nxt.rdata = port_stat[0];
          st_nxt.rvalid = 1'b1;
        end
        RHS_CMD_PORT2_RD: begin
          st_nxt.rdata = port_stat[1];
          st_nxt.rvalid = 1'b1;
        end
        RHS_CMD_HUB_WR: begin
          if (cmd_wdata[RHS_HUB_WAKE_CLR]) st_nxt.wake_en = 1'b0;
          if (cmd_wdata[RHS_HUB_WAKE_EN]) st_nxt.wake_en = 1'b1;
          if (cmd_wdata[RHS_HUB_OC_CHG]) st_nxt.oc_chg = 1'b0;
          if (cmd_wdata[RHS_HUB_LOCAL_PWR_CHG]) st_nxt.pwr_on = sel;
          if (cmd_wdata[RHS_HUB_LOCAL_PWR]) st_nxt.pwr_off = sel;
        end
        RHS_CMD_PORT1_WR, RHS_CMD_PORT2_WR: begin
          // One write may wait; a newer one replaces it
          st_nxt.pend = 1'b1;
          st_nxt.pend_sel = (cmd_code == RHS_CMD_PORT1_WR) ? 2'h1 : 2'h2;
          st_nxt.pend_data = cmd_wdata;
        end
        default: begin
          st_nxt.rdata = '0;
          st_nxt.rvalid = 1'b1;
        end
      endcase
    end
    // Hardware set wins over a same-cycle write-one clear
    if (oc_global != st_r.oc_last) st_nxt.oc_chg = 1'b1;
    if (st_r.wake_en && controller_suspended && (port_conn_evt != '0)) begin
      st_nxt.resume_irq = 1'b1;
      st_nxt.resume_req = 1'b1;
    end
    for (int k = 0; k < NUM_PORTS; k++) begin
      st_nxt.pwr_out[k] = port_stat[k][RHS_P_POWER_ON];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmd_rdata             = st_r.rdata;
  assign cmd_rvalid            = st_r.rvalid;
  assign port_power_on         = st_r.pwr_out;
  assign resume_seen_interrupt = st_r.resume_irq;
  assign resume_request        = st_r.resume_req;

endmodule : rhs_hub

// ### rhs_hub_checker.sv
module rhs_hub_checker
  import rhs_pkg::*;
#(
  parameter int NUM_PORTS = RHS_NUM_PORTS
)(
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 cmd_valid,
  input wire logic [7:0]           cmd_code,
  input wire logic [31:0]          cmd_wdata,
  input wire logic                 power_switch_select,
  input wire logic                 per_port_ocur_mode,
  input wire logic [NUM_PORTS-1:0] per_port_power_mask,
  input wire logic                 transaction_busy,
  input wire logic [31:0]          cmd_rdata,
  input wire logic                 cmd_rvalid,
  input wire logic [NUM_PORTS-1:0] port_power_on,
  input wire logic                 resume_seen_interrupt,
  input wire logic                 resume_request
);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic hub_wr = cmd_valid && cmd_code == RHS_CMD_HUB_WR;
  wire logic hub_rd = cmd_valid && cmd_code == RHS_CMD_HUB_RD;
  wire logic prt_rd = cmd_valid && (cmd_code == RHS_CMD_PORT1_RD || cmd_code == RHS_CMD_PORT2_RD);
  a_read_answer: assert property (hub_rd || prt_rd |=> cmd_rvalid)
    else $error("read got no answer");
  a_hub_zero_bits: assert property (hub_rd |=> (cmd_rdata & 32'hFFFD_7FFD) == 32'h0)
    else $error("hub reserved or power bits not zero");
  a_ocur_masked: assert property (hub_rd && per_port_ocur_mode
    |=> !cmd_rdata[RHS_HUB_OVERCURRENT]) else $error("hub overcurrent shown in per-port mode");
  a_global_on: assert property (hub_wr && cmd_wdata[16] && !cmd_wdata[0] && !power_switch_select
    |-> ##3 port_power_on == '1) else $error("global power on missed");
  a_global_off: assert property (hub_wr && cmd_wdata[0] && !cmd_wdata[16] && !power_switch_select
    |-> ##3 port_power_on == '0) else $error("global power off missed");
  a_mask_hold: assert property (hub_wr && cmd_wdata[16] && power_switch_select
    && per_port_power_mask[0] && !port_power_on[0] |-> ##3 !port_power_on[0])
    else $error("masked port took global power");
  // A port write may only land once the bus transaction is over
  a_write_defer: assert property ($rose(port_power_on[0])
    |-> !$past(transaction_busy, 2) || $past(hub_wr, 3)) else $error("port write not deferred");
  a_resume_pulse: assert property (resume_seen_interrupt
    |-> resume_request ##1 !resume_seen_interrupt) else $error("resume pulse malformed");
  c_global_on: cover property (hub_wr && cmd_wdata[16]);
  c_resume: cover property (resume_seen_interrupt);
  c_deferred: cover property ($rose(port_power_on[0]) && $past(transaction_busy, 3));
endmodule : rhs_hub_checker

bind rhs_hub rhs_hub_checker #(.NUM_PORTS(NUM_PORTS)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .power_switch_select(power_switch_select), .per_port_ocur_mode(per_port_ocur_mode),
  .per_port_power_mask(per_port_power_mask), .transaction_busy(transaction_busy),
  .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .port_power_on(port_power_on),
  .resume_seen_interrupt(resume_seen_interrupt), .resume_request(resume_request));

// ### testbench.sv
module testbench
  import rhs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  logic        clk_sys, rst_n, cmd_valid, power_switch_select, per_port_ocur_mode;
  logic        transaction_busy, controller_suspended, overcurrent_pin, cmd_rvalid;
  logic        resume_seen_interrupt, resume_request;
  logic [7:0]  cmd_code;
  logic [31:0] cmd_wdata, cmd_rdata, rd;
  logic [1:0]  per_port_power_mask, connect_pin, slow_pin, port_power_on;
  int          n_fail = 0, n_tests = 0, cyc = 0, n_res = 0, n_req = 0;

  // Unused event inputs are tied low; their logic is outside this bench
  rhs_hub #(.NUM_PORTS(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .power_switch_select(power_switch_select),
    .per_port_ocur_mode(per_port_ocur_mode), .per_port_power_mask(per_port_power_mask),
    .transaction_busy(transaction_busy), .controller_suspended(controller_suspended),
    .overcurrent_pin(overcurrent_pin), .connect_pin(connect_pin), .slow_pin(slow_pin),
    .port_ocur_pin(2'h0), .enable_lost(2'h0), .reset_done(2'h0), .resume_done(2'h0),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .port_power_on(port_power_on),
    .resume_seen_interrupt(resume_seen_interrupt), .resume_request(resume_request));

  always #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (resume_seen_interrupt === 1'b1) n_res++;
    if (resume_request === 1'b1) n_req++;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cmd(logic [7:0] c, logic [31:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    rd = cmd_rdata;
  endtask : cmd

  task automatic rdchk(string nm, logic [7:0] c, logic [31:0] exp);
    cmd(c, 32'h0);
    chk("rvalid", {31'h0, cmd_rvalid}, 32'h1);
    chk(nm, rd, exp);
  endtask : rdchk

  task automatic wt(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  task automatic pwr(string nm, logic [7:0] c, logic [31:0] d, logic [1:0] exp);
    cmd(c, d);
    wt(3);
    chk(nm, {30'h0, port_power_on}, {30'h0, exp});
  endtask : pwr

  task automatic t_reset;
    rdchk("hub", RHS_CMD_HUB_RD, 32'h0);
    rdchk("port1", RHS_CMD_PORT1_RD, RHS_PORT_RESET);
    rdchk("port2", RHS_CMD_PORT2_RD, RHS_PORT_RESET);
    rdchk("unknown", 8'h17, 32'h0);
  endtask : t_reset

  task automatic t_wake;
    cmd(RHS_CMD_HUB_WR, 32'h0000_8000);
    rdchk("wake_set", RHS_CMD_HUB_RD, 32'h0000_8000);
    cmd(RHS_CMD_HUB_WR, 32'h7FFC_7FFC);
    rdchk("wake_keep", RHS_CMD_HUB_RD, 32'h0000_8000);
    cmd(RHS_CMD_HUB_WR, 32'h8000_0000);
    rdchk("wake_clr", RHS_CMD_HUB_RD, 32'h0);
  endtask : t_wake

  task automatic t_resume;
    @(posedge clk_sys) controller_suspended <= 1'b1;
    @(posedge clk_sys) connect_pin <= 2'h1;
    slow_pin <= 2'h1;
    wt(12);
    chk("no_wake", 32'(n_res), 32'h0);
    rdchk("p1_conn", RHS_CMD_PORT1_RD, 32'h0001_0201);
    cmd(RHS_CMD_PORT1_WR, 32'h0001_0000);
    cmd(RHS_CMD_HUB_WR, 32'h0000_8000);
    @(posedge clk_sys) connect_pin <= 2'h3;
    wt(12);
    chk("wake", 32'(n_res), 32'h1);
    chk("wake_req", 32'(n_req), 32'h1);
    cmd(RHS_CMD_PORT2_WR, 32'h0001_0000);
    rdchk("p2_conn", RHS_CMD_PORT2_RD, 32'h0000_0001);
    @(posedge clk_sys) controller_suspended <= 1'b0;
  endtask : t_resume

  task automatic t_power;
    pwr("g_on", RHS_CMD_HUB_WR, 32'h0001_0000, 2'h3);
    rdchk("p2_pow", RHS_CMD_PORT2_RD, 32'h0000_0101);
    pwr("g_zero", RHS_CMD_HUB_WR, 32'h0, 2'h3);
    pwr("g_off", RHS_CMD_HUB_WR, 32'h0000_0001, 2'h0);
    @(posedge clk_sys) power_switch_select <= 1'b1;
    per_port_power_mask <= 2'h1;
    pwr("m_on", RHS_CMD_HUB_WR, 32'h0001_0000, 2'h2);
    pwr("m_port", RHS_CMD_PORT1_WR, 32'h0000_0100, 2'h3);
    pwr("m_off", RHS_CMD_HUB_WR, 32'h0000_0001, 2'h1);
    pwr("p_off", RHS_CMD_PORT1_WR, 32'h0000_0200, 2'h0);
  endtask : t_power

  // Port write held back by a busy bus, then released
  task automatic t_defer;
    @(posedge clk_sys) transaction_busy <= 1'b1;
    pwr("held", RHS_CMD_PORT1_WR, 32'h0000_0100, 2'h0);
    wt(4);
    chk("held_long", {30'h0, port_power_on}, 32'h0);
    @(posedge clk_sys) transaction_busy <= 1'b0;
    wt(3);
    chk("applied", {30'h0, port_power_on}, 32'h1);
  endtask : t_defer

  task automatic t_ocur;
    @(posedge clk_sys) overcurrent_pin <= 1'b1;
    wt(5);
    rdchk("oc_on", RHS_CMD_HUB_RD, 32'h0002_8002);
    cmd(RHS_CMD_HUB_WR, 32'h0002_0000);
    rdchk("oc_clr", RHS_CMD_HUB_RD, 32'h0000_8002);
    @(posedge clk_sys) overcurrent_pin <= 1'b0;
    wt(5);
    rdchk("oc_off", RHS_CMD_HUB_RD, 32'h0002_8000);
    cmd(RHS_CMD_HUB_WR, 32'h0002_0000);
    // Mode goes up on the same edge as the pin; the pin's two-stage synchronizer keeps the masked indicator still
    @(posedge clk_sys) per_port_ocur_mode <= 1'b1;
    overcurrent_pin <= 1'b1;
    wt(5);
    rdchk("oc_mode", RHS_CMD_HUB_RD, 32'h0000_8000);
  endtask : t_ocur

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0;
    power_switch_select = 1'b0;
    per_port_ocur_mode = 1'b0;
    per_port_power_mask = 2'h0;
    transaction_busy = 1'b0;
    controller_suspended = 1'b0;
    overcurrent_pin = 1'b0;
    connect_pin = 2'h0;
    slow_pin = 2'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_wake();
    t_resume();
    t_power();
    t_defer();
    t_ocur();
    conclude();
  end
endmodule : testbench
